// ### rtl/cmsd_top.sv
// cmsd_top: serial write port, reference monitor status and defaults
// assumes: pins arrive asynchronously; the serial clock is far slower than clk_sys
`timescale 1ns/1ps
module cmsd_top (
  input  wire logic       clk_sys,             // system clock, 100 MHz
  input  wire logic       sys_rst,             // async reset, active high
  input  wire logic       spi_cs_n,            // serial chip select, active low
  input  wire logic       spi_scl,             // serial clock pin
  input  wire logic       spi_sda,             // serial data pin
  input  wire logic       ref_a_fail,          // monitor: input a failed
  input  wire logic       ref_b_fail,          // monitor: input b failed
  input  wire logic       pll_locked,          // pll lock detect
  input  wire logic       input_select_pin_a,  // select pin a, enables input a when control a follows the pins
  input  wire logic       input_select_pin_b,  // select pin b, enables input b when control a follows the pins
  output logic      [7:0] ref_predivider_reg,    // predivider byte
  output logic      [7:0] feedback_div_low_reg,  // feedback low byte
  output logic      [7:0] feedback_div_high_reg, // feedback high byte
  output logic      [7:0] output_div_a_reg,      // output divider a
  output logic      [7:0] output_div_b_reg,      // output divider b
  output logic      [7:0] control_reg_a,         // control a
  output logic      [7:0] control_reg_b,         // control b
  output logic      [7:0] spare_reg,             // spare byte
  output logic      [7:0] input_monitor_status,  // status register
  output logic            alarm_out,             // monitor alarm, high
  output logic            ref_select,            // 0 input a, 1 input b
  output logic            holdover_out           // holdover active
);

  typedef struct packed {
    logic [1:0]                   cs_s;     // chip select sync
    logic [2:0]                   scl_s;    // serial clock sync plus edge tap
    logic [1:0]                   sda_s;    // serial data sync
    logic [1:0]                   fa_s;     // failure a sync
    logic [1:0]                   fb_s;     // failure b sync
    logic [1:0]                   lk_s;     // lock sync
    logic [1:0]                   pa_s;     // select pin a sync
    logic [1:0]                   pb_s;     // select pin b sync
    cmsd_pkg::cmsd_spi_state_type fsm;      // receiver state
    logic [15:0]                  shift;    // incoming frame
    logic [4:0]                   cnt;      // bits taken this frame
    logic                         wr_stb;   // write strobe to registers
    logic [6:0]                   wr_addr;  // write address
    logic [7:0]                   wr_data;  // write data
    logic                         sel;      // active reference
    logic                         alarm;    // sticky alarm
    logic                         hold;     // holdover state
    logic [7:0]                   status;   // status register
  } cmsd_top_state_type;

  cmsd_top_state_type st_reg;   // registered state
  cmsd_top_state_type st_next;  // next state
  logic               soft_rst; // master reset from a control b write

  // an input is usable when enabled and healthy
  function automatic logic usable(input logic en, input logic fail);
    return en & ~fail;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register bytes live in their own module
  assign soft_rst = st_reg.wr_stb && st_reg.wr_addr == cmsd_pkg::ADDR_CTRL_B &&
                    st_reg.wr_data[cmsd_pkg::CB_MASTER_RST];

  cmsd_regfile u_regs (
    .clk_sys               (clk_sys),
    .sys_rst               (sys_rst),
    .wr_en                 (st_reg.wr_stb),
    .wr_addr               (st_reg.wr_addr),
    .wr_data               (st_reg.wr_data),
    .soft_rst              (soft_rst),
    .ref_predivider_reg    (ref_predivider_reg),
    .feedback_div_low_reg  (feedback_div_low_reg),
    .feedback_div_high_reg (feedback_div_high_reg),
    .output_div_a_reg      (output_div_a_reg),
    .output_div_b_reg      (output_div_b_reg),
    .control_reg_a         (control_reg_a),
    .control_reg_b         (control_reg_b),
    .spare_reg             (spare_reg)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state: synchronisers, serial receiver, reference monitor
  always_comb begin
    logic en_a;      // input a enabled
    logic en_b;      // input b enabled
    logic ok_a;      // input a usable
    logic ok_b;      // input b usable
    logic mon_rst;   // monitor reset write in revert mode
    logic cur_fail;  // active input reports failure
    en_a     = 1'b0;
    en_b     = 1'b0;
    ok_a     = 1'b0;
    ok_b     = 1'b0;
    mon_rst  = 1'b0;
    cur_fail = 1'b0;
    st_next  = st_reg;
    // two flops per pin, three on scl for the edge tap; only stage 1 of each is read as a plain copy
    st_next.cs_s  = {st_reg.cs_s[0], spi_cs_n};
    st_next.scl_s = {st_reg.scl_s[1:0], spi_scl};
    st_next.sda_s = {st_reg.sda_s[0], spi_sda};
    st_next.fa_s  = {st_reg.fa_s[0], ref_a_fail};
    st_next.fb_s  = {st_reg.fb_s[0], ref_b_fail};
    st_next.lk_s  = {st_reg.lk_s[0], pll_locked};
    st_next.pa_s  = {st_reg.pa_s[0], input_select_pin_a};
    st_next.pb_s  = {st_reg.pb_s[0], input_select_pin_b};
    st_next.wr_stb = 1'b0;

    // receiver: no read path exists, a frame with its top bit set is dropped
    unique case (st_reg.fsm)
      cmsd_pkg::SPI_IDLE: begin
        if (!st_reg.cs_s[1]) begin
          st_next.fsm = cmsd_pkg::SPI_SHIFT;
          st_next.cnt = 5'h00;
        end
      end
      cmsd_pkg::SPI_SHIFT: begin
        if (st_reg.cs_s[1]) begin
          st_next.fsm = cmsd_pkg::SPI_DONE;  // boundary of a word
        end else if (st_reg.scl_s[1] && !st_reg.scl_s[2]) begin
          st_next.shift = {st_reg.shift[14:0], st_reg.sda_s[1]};
          if (st_reg.cnt != cmsd_pkg::CNT_SAT) begin
            st_next.cnt = st_reg.cnt + 5'h01;  // saturates on overlong frames
          end
        end
      end
      cmsd_pkg::SPI_DONE: begin
        st_next.fsm = cmsd_pkg::SPI_IDLE;
        if (st_reg.cnt == cmsd_pkg::FRAME_CNT && !st_reg.shift[15]) begin
          st_next.wr_stb  = 1'b1;
          st_next.wr_addr = st_reg.shift[14:8];
          st_next.wr_data = st_reg.shift[7:0];
        end
      end
      default: begin
        st_next.fsm = cmsd_pkg::SPI_IDLE;  // recover from an illegal code
      end
    endcase

    // input enabling from control a, or from the pins
    unique case (control_reg_a[cmsd_pkg::CA_IN_EN_HI:cmsd_pkg::CA_IN_EN_LO])
      cmsd_pkg::IN_EN_PINS: begin
        en_a = st_reg.pa_s[1];
        en_b = st_reg.pb_s[1];
      end
      cmsd_pkg::IN_EN_A: begin
        en_a = 1'b1;
      end
      cmsd_pkg::IN_EN_B: begin
        en_b = 1'b1;
      end
      default: begin
        en_a = 1'b1;
        en_b = 1'b1;
      end
    endcase
    ok_a = usable(en_a, st_reg.fa_s[1]);
    ok_b = usable(en_b, st_reg.fb_s[1]);

    // monitor reset only counts while the revert function is on
    mon_rst = st_reg.wr_stb && st_reg.wr_addr == cmsd_pkg::ADDR_CTRL_A &&
              st_reg.wr_data[cmsd_pkg::CA_MON_RESET] &&
              st_reg.wr_data[cmsd_pkg::CA_REVERT];
    cur_fail = st_reg.sel ? st_reg.fb_s[1] : st_reg.fa_s[1];

    if (soft_rst) begin
      st_next.sel   = 1'b0;  // master reset: default input a
      st_next.alarm = 1'b0;
    end else if (mon_rst) begin
      st_next.sel   = st_reg.wr_data[cmsd_pkg::CA_DEFAULT_IN];
      st_next.alarm = 1'b0;
    end else if (st_reg.sel ? (!ok_b && ok_a) : (!ok_a && ok_b)) begin
      st_next.sel = ~st_reg.sel;  // switch away from a dead reference
    end
    // a failure in the clearing cycle still sets the alarm
    if (cur_fail) begin
      st_next.alarm = 1'b1;
    end

    // holdover only under its enable, forced or with no usable input
    st_next.hold = control_reg_b[cmsd_pkg::CB_HOLD_EN] &
                   (control_reg_b[cmsd_pkg::CB_HOLD_FORCE] | (~ok_a & ~ok_b));

    // status is built from block state and the monitor reset default input bit; writes to the status address never reach it
    st_next.status = {st_next.alarm,     // alarm
                      st_reg.fa_s[1],
                      st_reg.fb_s[1],
                      st_next.sel,
                      ~st_reg.lk_s[1],
                      st_next.hold,
                      2'b00};
  end

  // register the state; every field takes a constant under reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg        <= '0;
      st_reg.cs_s   <= 2'h3;
      st_reg.fsm    <= cmsd_pkg::SPI_IDLE;
      st_reg.status <= cmsd_pkg::RST_ZERO;
    end else begin
      st_reg <= st_next;
    end
  end

  assign input_monitor_status = st_reg.status;
  assign alarm_out            = st_reg.alarm;
  assign ref_select           = st_reg.sel;
  assign holdover_out         = st_reg.hold;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_mon_rst;
    st_reg.wr_stb && st_reg.wr_addr == 7'h05 && st_reg.wr_data[1] && st_reg.wr_data[0];
  endsequence
  sequence s_quiet;
    !st_reg.fa_s[1] && !st_reg.fb_s[1] && !soft_rst;
  endsequence

  AST_FAIL_A: assert property (ref_a_fail [*3] |=> input_monitor_status[6])
    else $error("input a failure not reported");
  AST_OK_B: assert property (!ref_b_fail [*3] |=> !input_monitor_status[5])
    else $error("healthy input b reported failed");
  AST_SEL: assert property ((s_mon_rst and s_quiet) |=>
    input_monitor_status[4] == $past(st_reg.wr_data[4]) && ref_select == input_monitor_status[4])
    else $error("selection bit not at default input after monitor reset");
  AST_UNLOCK: assert property (!pll_locked [*3] |=> input_monitor_status[3])
    else $error("unlocked pll not reported");
  AST_RESV: assert property (input_monitor_status[1:0] == 2'b00 &&
    input_monitor_status[2] == holdover_out)
    else $error("reserved status bits set or holdover bit mismatched");
  AST_HOLD_FORCE: assert property (control_reg_b[7:6] == 2'b11 |=> input_monitor_status[2])
    else $error("forced holdover not reported");
  AST_HOLD_EN: assert property (!control_reg_b[7] |=> !input_monitor_status[2])
    else $error("holdover without enable");
  AST_ALARM_CLR: assert property ((s_mon_rst and s_quiet) |=>
    !alarm_out && !input_monitor_status[7])
    else $error("alarm not cleared by monitor reset");
  AST_WRITE_ONLY: assert property (st_reg.wr_stb |-> $past(st_reg.shift[15]) == 1'b0)
    else $error("frame with top bit set was written");
  AST_STATUS_RO: assert property ((st_reg.wr_stb && st_reg.wr_addr == 7'h07 &&
    st_reg.wr_data[3:2] != 2'b00) |=> input_monitor_status[1:0] == 2'b00 &&
    input_monitor_status[3] == !$past(st_reg.lk_s[1]))
    else $error("status register altered by a host write");

endmodule // cmsd_top

// ### inc/cmsd_pkg.sv
// cmsd_pkg: shared constants for the clock monitor status and defaults block
// assumes: byte-wide registers reached over a serial write-only control port
package cmsd_pkg;

  // register addresses, seven bits as carried in a serial frame
  localparam logic [6:0] ADDR_PREDIV   = 7'h00;  // reference predivider
  localparam logic [6:0] ADDR_FB_LOW   = 7'h01;  // feedback divider low byte
  localparam logic [6:0] ADDR_FB_HIGH  = 7'h02;  // feedback divider high byte
  localparam logic [6:0] ADDR_ODIV_A   = 7'h03;  // output divider a
  localparam logic [6:0] ADDR_ODIV_B   = 7'h04;  // output divider b
  localparam logic [6:0] ADDR_CTRL_A   = 7'h05;  // control register a
  localparam logic [6:0] ADDR_CTRL_B   = 7'h06;  // control register b
  localparam logic [6:0] ADDR_STATUS   = 7'h07;  // input monitor status
  localparam logic [6:0] ADDR_SPARE    = 7'h08;  // spare register
  localparam int         NUM_REGS      = 9;      // registers in the map

  // power-up values
  localparam logic [7:0] RST_ZERO      = 8'h00;  // dividers, status, spare
  localparam logic [7:0] RST_CTRL_A    = 8'h60;  // both outputs enabled
  localparam logic [7:0] RST_CTRL_B    = 8'h00;  // holdover disabled

  // control a fields
  localparam int CA_DEFAULT_IN  = 4;  // default input select
  localparam int CA_IN_EN_HI    = 3;  // input enabling field msb
  localparam int CA_IN_EN_LO    = 2;  // input enabling field lsb
  localparam int CA_REVERT      = 1;  // revert function on
  localparam int CA_MON_RESET   = 0;  // clock monitor reset

  // control b fields
  localparam int CB_HOLD_EN     = 7;  // holdover enable
  localparam int CB_HOLD_FORCE  = 6;  // forced holdover
  localparam int CB_MASTER_RST  = 4;  // master reset

  // status fields
  localparam int ST_ALARM       = 7;  // sticky monitor alarm
  localparam int ST_FAIL_A      = 6;  // input a failed
  localparam int ST_FAIL_B      = 5;  // input b failed
  localparam int ST_SEL         = 4;  // active reference
  localparam int ST_UNLOCK      = 3;  // pll not locked
  localparam int ST_HOLD        = 2;  // holdover state

  // input enabling codes
  localparam logic [1:0] IN_EN_PINS = 2'h0;  // follow select pins
  localparam logic [1:0] IN_EN_A    = 2'h1;  // a only
  localparam logic [1:0] IN_EN_B    = 2'h2;  // b only

  // serial frame
  localparam int         FRAME_BITS = 16;     // bits per write word
  localparam logic [4:0] FRAME_CNT  = 5'h10;  // complete frame count
  localparam logic [4:0] CNT_SAT    = 5'h11;  // overlong frame marker

  // serial receiver states
  typedef enum logic [2:0] {
    SPI_IDLE  = 3'b001,
    SPI_SHIFT = 3'b010,
    SPI_DONE  = 3'b100
  } cmsd_spi_state_type;

endpackage

// ### rtl/cmsd_regfile.sv
// cmsd_regfile: the byte registers of the map, written by the serial port
// assumes: one write strobe per frame from the same clock domain
`timescale 1ns/1ps
module cmsd_regfile (
  input  wire logic       clk_sys,       // system clock
  input  wire logic       sys_rst,       // async reset, active high
  input  wire logic       wr_en,         // one-cycle write strobe
  input  wire logic [6:0] wr_addr,       // register address
  input  wire logic [7:0] wr_data,       // write data
  input  wire logic       soft_rst,      // master reset request
  output logic      [7:0] ref_predivider_reg,     // predivider byte
  output logic      [7:0] feedback_div_low_reg,   // feedback low byte
  output logic      [7:0] feedback_div_high_reg,  // feedback high byte
  output logic      [7:0] output_div_a_reg,       // output divider a
  output logic      [7:0] output_div_b_reg,       // output divider b
  output logic      [7:0] control_reg_a,          // control a
  output logic      [7:0] control_reg_b,          // control b
  output logic      [7:0] spare_reg               // spare byte
);

  typedef struct packed {
    logic [cmsd_pkg::NUM_REGS-1:0][7:0] mem;   // register bytes
    logic                               first; // first cycle after reset
  } cmsd_rf_state_type;

  cmsd_rf_state_type st_reg;   // registered state
  cmsd_rf_state_type st_next;  // next state

  // power-up image; the status slot stays zero here, the top owns it
  function automatic logic [cmsd_pkg::NUM_REGS-1:0][7:0] defaults();
    logic [cmsd_pkg::NUM_REGS-1:0][7:0] d;
    d = '0;
    d[cmsd_pkg::ADDR_CTRL_A] = cmsd_pkg::RST_CTRL_A;
    d[cmsd_pkg::ADDR_CTRL_B] = cmsd_pkg::RST_CTRL_B;
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state: master reset beats a write, status slot never written
  always_comb begin
    st_next       = st_reg;
    st_next.first = 1'b0;
    if (soft_rst) begin
      st_next.mem = defaults();
    end else if (wr_en && wr_addr != cmsd_pkg::ADDR_STATUS &&
                 wr_addr < 7'(cmsd_pkg::NUM_REGS)) begin
      st_next.mem[wr_addr[3:0]] = wr_data;
    end
  end

  // register the state; constants only under reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg.mem   <= defaults();
      st_reg.first <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ref_predivider_reg    = st_reg.mem[cmsd_pkg::ADDR_PREDIV];
  assign feedback_div_low_reg  = st_reg.mem[cmsd_pkg::ADDR_FB_LOW];
  assign feedback_div_high_reg = st_reg.mem[cmsd_pkg::ADDR_FB_HIGH];
  assign output_div_a_reg      = st_reg.mem[cmsd_pkg::ADDR_ODIV_A];
  assign output_div_b_reg      = st_reg.mem[cmsd_pkg::ADDR_ODIV_B];
  assign control_reg_a         = st_reg.mem[cmsd_pkg::ADDR_CTRL_A];
  assign control_reg_b         = st_reg.mem[cmsd_pkg::ADDR_CTRL_B];
  assign spare_reg             = st_reg.mem[cmsd_pkg::ADDR_SPARE];

  ////////////////////////////////////////////////////////////////////////
  // checks on the reset image
  AST_DIV_DEFAULTS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_reg.first |-> (ref_predivider_reg == 8'h00 && feedback_div_low_reg == 8'h00 &&
      feedback_div_high_reg == 8'h00 && output_div_a_reg == 8'h00 &&
      output_div_b_reg == 8'h00 && spare_reg == 8'h00))
    else $error("divider registers not cleared after reset");
  AST_CTRL_DEFAULTS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (st_reg.first || $past(soft_rst)) |-> (control_reg_a == 8'h60 && control_reg_b == 8'h00))
    else $error("control registers not at default after reset");

endmodule // cmsd_regfile

// ### test/cmsd_host_model.sv
// cmsd_host_model: host controller on the serial write port
// assumes: send() is called from one process; bench clock is 100 MHz
`timescale 1ns/1ps
module cmsd_host_model (
  input  wire logic clk_sys,   // system clock
  output logic      spi_cs_n,  // chip select, active low
  output logic      spi_scl,   // serial clock, still between frames
  output logic      spi_sda    // serial data
);
  logic busy;  // frame in flight

  ////////////////////////////////////////////////////////////////////
  // idle levels at time zero
  initial begin
    spi_cs_n = 1'b1;
    spi_scl  = 1'b0;
    spi_sda  = 1'b0;
    busy     = 1'b0;
  end

  // unselected data line toggles so a stale bit never passes as data
  always @(negedge clk_sys) begin
    if (!busy) begin
      spi_sda <= ~spi_sda;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // one frame, msb first; half is the scl high phase in clk cycles, the low phase lasts twice that
  task automatic send(input logic [15:0] word, input int nbits, input int half);
    busy = 1'b1;
    @(negedge clk_sys);
    spi_cs_n <= 1'b0;  // scl is already low at select
    for (int i = 0; i < nbits; i++) begin
      repeat (half) @(negedge clk_sys);
      spi_sda <= (i < 16) ? word[15 - i] : 1'b0;  // write-only frame
      repeat (half) @(negedge clk_sys);
      spi_scl <= 1'b1;
      repeat (half) @(negedge clk_sys);
      spi_scl <= 1'b0;
    end
    repeat (half) @(negedge clk_sys);
    spi_cs_n <= 1'b1;
    busy = 1'b0;
    // gap covers write latency and the minimum deselect time
    repeat (8) @(negedge clk_sys);
  endtask
endmodule // cmsd_host_model

// ### test/clock_monitor_status_defaults_tb.sv
// clock_monitor_status_defaults_tb: self-checking bench for cmsd_top
// assumes: host model drives the serial port; pins driven at falling edge
`timescale 1ns/1ps
module clock_monitor_status_defaults_tb;
  logic            clk_sys;             // system clock
  logic            sys_rst;             // reset, active high
  logic            spi_cs_n;            // chip select from host
  logic            spi_scl;             // serial clock from host
  logic            spi_sda;             // serial data from host
  logic            ref_a_fail;          // monitor pin a
  logic            ref_b_fail;          // monitor pin b
  logic            pll_locked;          // lock pin
  logic            input_select_pin_a;  // enable pin a
  logic            input_select_pin_b;  // enable pin b
  logic            alarm_out;           // sticky alarm
  logic            ref_select;          // active reference
  logic            holdover_out;        // holdover flag
  wire logic [8:0][7:0] reg_seen;       // outputs by address, 7 = status
  logic [8:0][7:0] shadow;              // expected register bytes
  int              err_total;           // mismatches
  int              n_tests;             // comparisons
  logic [15:0]     corner   [0:7] = '{16'h07ff, 16'h09aa, 16'h7f55, 16'h8155,
                                      16'h0155, 16'h0155, 16'h08a5, 16'h00ff};
  int              corner_n [0:7] = '{16, 16, 16, 16, 15, 17, 16, 16};

  ////////////////////////////////////////////////////////////////////
  cmsd_host_model host (
    .clk_sys  (clk_sys),
    .spi_cs_n (spi_cs_n),
    .spi_scl  (spi_scl),
    .spi_sda  (spi_sda)
  );

  cmsd_top DUT (
    .clk_sys               (clk_sys),
    .sys_rst               (sys_rst),
    .spi_cs_n              (spi_cs_n),
    .spi_scl               (spi_scl),
    .spi_sda               (spi_sda),
    .ref_a_fail            (ref_a_fail),
    .ref_b_fail            (ref_b_fail),
    .pll_locked            (pll_locked),
    .input_select_pin_a    (input_select_pin_a),
    .input_select_pin_b    (input_select_pin_b),
    .ref_predivider_reg    (reg_seen[0]),
    .feedback_div_low_reg  (reg_seen[1]),
    .feedback_div_high_reg (reg_seen[2]),
    .output_div_a_reg      (reg_seen[3]),
    .output_div_b_reg      (reg_seen[4]),
    .control_reg_a         (reg_seen[5]),
    .control_reg_b         (reg_seen[6]),
    .spare_reg             (reg_seen[8]),
    .input_monitor_status  (reg_seen[7]),
    .alarm_out             (alarm_out),
    .ref_select            (ref_select),
    .holdover_out          (holdover_out)
  );

  ////////////////////////////////////////////////////////////////////
  // a frame lands only when whole, a write, and aimed at a writable byte
  function automatic logic frame_taken(input logic [15:0] w, input int n);
    return (n == 16) && !w[15] && (w[14:8] != 7'h07) && (w[14:8] < 7'h09);
  endfunction

  // power-up image: all zero except control a
  task automatic set_defaults();
    shadow    = '0;
    shadow[5] = 8'h60;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // every writable byte against the expected image
  task automatic check_regs();
    for (int a = 0; a < 9; a++) begin
      if (a != 7) check(reg_seen[a], shadow[a]);
    end
  endtask

  // six cycles cover the three-cycle pin latency with margin
  task automatic chk_status(input logic [7:0] e);
    repeat (6) @(negedge clk_sys);
    check(reg_seen[7], e);
    check({5'h00, alarm_out, ref_select, holdover_out}, {5'h00, e[7], e[4], e[2]});
  endtask

  task automatic test_done(input string name);
    $display("test %s done", name);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    err_total++;  // hang cut short
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [15:0] w;
    int          n;
    sys_rst            = 1'b1;
    ref_a_fail         = 1'b0;
    ref_b_fail         = 1'b0;
    pll_locked         = 1'b1;
    input_select_pin_a = 1'b1;
    input_select_pin_b = 1'b1;
    err_total          = 0;
    n_tests            = 0;
    void'($urandom(47769));
    set_defaults();
    repeat (2) @(negedge clk_sys);
    check_regs();
    check(reg_seen[7], 8'h00);
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    test_done("reset");
    // corners first, then random frames, good and refused mixed
    for (int i = 0; i < 45; i++) begin
      if (i < 8) begin
        w = corner[i];
        n = corner_n[i];
      end else begin
        w = {($urandom_range(0, 3) == 0), 7'($urandom_range(0, 10)), 8'($urandom)};
        n = ($urandom_range(0, 7) == 0) ? 15 + 2 * $urandom_range(0, 1) : 16;
      end
      if (w[14:8] == 7'h06) w[4] = 1'b0;  // soft reset kept out of the mix
      host.send(w, n, 3 + 2 * $urandom_range(0, 1));
      if (frame_taken(w, n)) shadow[w[14:8]] = w[7:0];
      check_regs();
    end
    host.send(16'h0610, 16, 3);
    set_defaults();
    check_regs();
    test_done("random frames");
    pll_locked = 1'b0;
    chk_status(8'h08);
    pll_locked = 1'b1;
    chk_status(8'h00);
    ref_b_fail = 1'b1;
    chk_status(8'h20);
    ref_b_fail = 1'b0;
    ref_a_fail = 1'b1;
    chk_status(8'hd0);
    ref_a_fail = 1'b0;
    chk_status(8'h90);
    host.send(16'h07ff, 16, 3);
    chk_status(8'h90);
    test_done("monitor");
    host.send(16'h0680, 16, 3);
    ref_a_fail = 1'b1;
    ref_b_fail = 1'b1;
    chk_status(8'hf4);
    host.send(16'h0600, 16, 3);
    chk_status(8'hf0);
    ref_a_fail = 1'b0;
    ref_b_fail = 1'b0;
    chk_status(8'h90);
    host.send(16'h0563, 16, 3);
    chk_status(8'h00);
    host.send(16'h0610, 16, 3);
    check_regs();
    test_done("holdover and monitor reset");
    // pin b disables input b, so a failing input a has nowhere to go
    input_select_pin_b = 1'b0;
    ref_a_fail         = 1'b1;
    chk_status(8'hc0);
    ref_a_fail         = 1'b0;
    input_select_pin_b = 1'b1;
    chk_status(8'h80);
    host.send(16'h06c0, 16, 3);
    chk_status(8'h84);
    host.send(16'h0610, 16, 3);
    chk_status(8'h00);
    test_done("select pins and forced holdover");
    end_sim();
  end
endmodule // clock_monitor_status_defaults_tb
